// ==== hw/rpa_alu_core.sv ====
/*
  Combinational 24-bit ALU of the RAM-pointer datapath: result and flag candidates.
  Assumes operands are already selected; flag update policy lives in the caller.
*/
module rpa_alu_core (
  input wire rpa_pkg::rpa_op_e op,
  input wire logic [rpa_pkg::DATA_W-1:0] a,
  input wire logic [rpa_pkg::DATA_W-1:0] b,
  input wire logic carry_in,
  output logic [rpa_pkg::DATA_W-1:0] result,
  output logic carry_out,
  output logic ovfl_out,
  output logic calc
);
  logic [rpa_pkg::DATA_W:0] wide;
  logic [2*rpa_pkg::DATA_W-1:0] prod;

  always_comb
  begin
    wide = '0;
    prod = '0;
    result = a;
    carry_out = carry_in;
    ovfl_out = 1'b0;
    calc = 1'b0;
    case (op)
      rpa_pkg::OP_ADD, rpa_pkg::OP_INCR:
      begin
        wide = {1'b0, a} + {1'b0, (op == rpa_pkg::OP_INCR) ? rpa_pkg::ONE_W : b};
        result = wide[rpa_pkg::DATA_W-1:0];
        carry_out = wide[rpa_pkg::DATA_W];
        ovfl_out = (a[rpa_pkg::MSB] == wide[rpa_pkg::MSB-1+1] ? 1'b0 : 1'b1)
          & ~(a[rpa_pkg::MSB] ^ ((op == rpa_pkg::OP_INCR) ? 1'b0 : b[rpa_pkg::MSB]));
        calc = 1'b1;
      end
      rpa_pkg::OP_SUB, rpa_pkg::OP_DECR, rpa_pkg::OP_COMPARE:
      begin
        // Compare takes b minus a; sub takes a minus b and decr takes a minus one
        if (op == rpa_pkg::OP_COMPARE)
        begin
          wide = {1'b0, b} - {1'b0, a};
          ovfl_out = (b[rpa_pkg::MSB] ^ a[rpa_pkg::MSB])
            & (b[rpa_pkg::MSB] ^ wide[rpa_pkg::MSB]);
        end
        else
        begin
          wide = {1'b0, a} - {1'b0, (op == rpa_pkg::OP_DECR) ? rpa_pkg::ONE_W : b};
          ovfl_out = (a[rpa_pkg::MSB] ^ ((op == rpa_pkg::OP_DECR) ? 1'b0 : b[rpa_pkg::MSB]))
            & (a[rpa_pkg::MSB] ^ wide[rpa_pkg::MSB]);
        end
        result = wide[rpa_pkg::DATA_W-1:0];
        carry_out = wide[rpa_pkg::DATA_W];
        calc = 1'b1;
      end
      rpa_pkg::OP_SHIFTL:
      begin
        result = {a[rpa_pkg::MSB-1:0], 1'b0};
        carry_out = a[rpa_pkg::MSB];
        calc = 1'b1;
      end
      rpa_pkg::OP_SHIFTR:
      begin
        result = {a[rpa_pkg::MSB], a[rpa_pkg::MSB:1]};
        carry_out = a[0];
        calc = 1'b1;
      end
      rpa_pkg::OP_ROTL:
      begin
        result = {a[rpa_pkg::MSB-1:0], carry_in};
        carry_out = a[rpa_pkg::MSB];
        calc = 1'b1;
      end
      rpa_pkg::OP_ROTR:
      begin
        result = {carry_in, a[rpa_pkg::MSB:1]};
        carry_out = a[0];
        calc = 1'b1;
      end
      rpa_pkg::OP_AND: result = a & b;
      rpa_pkg::OP_OR: result = a | b;
      rpa_pkg::OP_EOR: result = a ^ b;
      rpa_pkg::OP_COMPL: result = rpa_pkg::ZERO_W - a;
      rpa_pkg::OP_ABS:
      begin
        result = a[rpa_pkg::MSB] ? rpa_pkg::ZERO_W - a : a;
        carry_out = 1'b0;
        ovfl_out = a[rpa_pkg::MSB] & result[rpa_pkg::MSB];
        calc = 1'b1;
      end
      rpa_pkg::OP_MULT24:
      begin
        // Low product word only; the high half is dropped by design
        prod = a * b;
        result = prod[rpa_pkg::DATA_W-1:0];
      end
      rpa_pkg::OP_MOVE, rpa_pkg::OP_GETEPR: result = b;
      rpa_pkg::OP_CLEAR: result = rpa_pkg::ZERO_W;
      default: result = a;
    endcase
  end
endmodule // rpa_alu_core

// ==== hw/rpa_datapath.sv ====
/*
  RAM-pointer ALU datapath: accumulators X/Y/Z, 256x24 RAM with pointer-selected
  fourth accumulator, 128-byte user EEPROM on the same pointer, four condition flags.
  Assumes the instruction decoder issues at most one command per clock, holds it
  for exactly one cycle, and drives the boot and front-end write ports.
*/
// Contract
// - Data RAM has 256 words of 24 bits on its own address.
// - Pointer maps one RAM word into the ALU as fourth accumulator.
// - Changing the pointer never alters any RAM content.
// - Pointer changes only by load, increment or decrement commands.
// - Pointer also addresses one byte of the 128-byte user EEPROM.
// - EEPROM store/fetch use the EEPROM; other pointer users use RAM.
// - Three 24-bit accumulators X, Y and Z exist besides the RAM word.
// - Transfers and arithmetic accept any of the four accumulators.
// - Four flags; not-equal and sign update on every accumulator write.
// - Carry and overflow update only on calculating operations.
// - Each flag can be tested individually for jumps.
// - Carry holds add/sub carry or borrow, or the shifted-out bit.
// - A nonzero result written clears the not-equal-zero flag.
// - Sign flag is set when the written result MSB is one.
// - Overflow flags signed overflow of addition or subtraction.
// - Status and result words live at RAM 240 to 255.
// - Words 240-249 hold bridge ratios, sum, temperature, status, TDC, cal, supply.
// - Words 250-255 hold key edges/state, pin state, timer and span ratio.
// - Front-end mode mirrors results at 16-31; stand-alone keeps user RAM.
// - Internal, UART, system, reserved and result ranges are protected; rest is user RAM.
// - Bridge, sum and temperature results are 24-bit two's complement.
// - Bridge ratio step is one hundredth ppm of resistance change.
// - Supply voltage equals 2.0 V plus 1.6 V times value over 64.
// - At reset sixteen configuration words fill RAM 48 to 63.
// - Flags always reflect the latest operation affecting them.
module rpa_datapath (
  input wire logic clk,
  input wire logic resetn,
  input wire rpa_pkg::rpa_cmd_s cmd,
  input wire rpa_pkg::rpa_cond_e cond_sel,
  input wire logic front_end_mode,
  input wire rpa_pkg::rpa_fe_wr_s fe_wr,
  input wire logic [rpa_pkg::DATA_W-1:0] cfg_word,
  output logic [3:0] cfg_index,
  output logic boot_busy,
  output logic cond_true,
  output rpa_pkg::rpa_flags_s flags,
  output logic [rpa_pkg::ADDR_W-1:0] ram_ptr,
  output logic [rpa_pkg::DATA_W-1:0] acc_x,
  output logic [rpa_pkg::DATA_W-1:0] acc_y,
  output logic [rpa_pkg::DATA_W-1:0] acc_z,
  output logic [rpa_pkg::DATA_W-1:0] acc_r
);
  logic [rpa_pkg::DATA_W-1:0] ram_reg [rpa_pkg::RAM_WORDS];
  logic [7:0] epr_reg [rpa_pkg::EPR_BYTES];
  logic [rpa_pkg::DATA_W-1:0] x_reg;
  logic [rpa_pkg::DATA_W-1:0] y_reg;
  logic [rpa_pkg::DATA_W-1:0] z_reg;
  logic [rpa_pkg::ADDR_W-1:0] ptr_reg;
  logic [rpa_pkg::ADDR_W-1:0] ptr_next;
  rpa_pkg::rpa_flags_s flags_reg;
  rpa_pkg::rpa_flags_s flags_next;
  rpa_pkg::rpa_state_e state_reg;
  logic [3:0] boot_cnt_reg;
  logic cond_reg;
  logic [rpa_pkg::DATA_W-1:0] r_word;
  logic [rpa_pkg::DATA_W-1:0] opa;
  logic [rpa_pkg::DATA_W-1:0] opb;
  logic [rpa_pkg::DATA_W-1:0] epr_ext;
  logic [rpa_pkg::DATA_W-1:0] alu_res;
  logic alu_c;
  logic alu_v;
  logic alu_calc;
  logic run;
  logic wr_dst;
  logic wr_src;
  logic [rpa_pkg::DATA_W-1:0] wr_dst_val;
  logic [rpa_pkg::ADDR_W-1:0] mirror_addr;
  logic mirror_hit;

  function automatic logic [rpa_pkg::DATA_W-1:0] acc_sel(
    input rpa_pkg::rpa_acc_e sel,
    input logic [rpa_pkg::DATA_W-1:0] xv,
    input logic [rpa_pkg::DATA_W-1:0] yv,
    input logic [rpa_pkg::DATA_W-1:0] zv,
    input logic [rpa_pkg::DATA_W-1:0] rv
  );
    case (sel)
      rpa_pkg::ACC_X: acc_sel = xv;
      rpa_pkg::ACC_Y: acc_sel = yv;
      rpa_pkg::ACC_Z: acc_sel = zv;
      default: acc_sel = rv;
    endcase
  endfunction

  function automatic logic in_range(
    input logic [rpa_pkg::ADDR_W-1:0] a,
    input logic [rpa_pkg::ADDR_W-1:0] lo,
    input logic [rpa_pkg::ADDR_W-1:0] hi
  );
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Program writes to internal, UART, reserved, system and result words are dropped
  function automatic logic user_writable(input logic [rpa_pkg::ADDR_W-1:0] a);
    user_writable = !(in_range(a, rpa_pkg::ADDR_INT_LO, rpa_pkg::ADDR_RSV_HI)
      || in_range(a, rpa_pkg::ADDR_SYS_LO, rpa_pkg::ADDR_RESULT_HI));
  endfunction

  assign run = (state_reg == rpa_pkg::ST_RUN) && cmd.valid;
  assign r_word = ram_reg[ptr_reg];
  assign epr_ext = {{(rpa_pkg::DATA_W-8){1'b0}}, epr_reg[ptr_reg[rpa_pkg::EPR_AW-1:0]]};
  assign opa = acc_sel(cmd.dst, x_reg, y_reg, z_reg, r_word);
  assign opb = (cmd.op == rpa_pkg::OP_GETEPR) ? epr_ext :
    cmd.src_imm ? cmd.imm : acc_sel(cmd.src, x_reg, y_reg, z_reg, r_word);

  rpa_alu_core u_alu (
    .op(cmd.op),
    .a(opa),
    .b(opb),
    .carry_in(flags_reg.carry),
    .result(alu_res),
    .carry_out(alu_c),
    .ovfl_out(alu_v),
    .calc(alu_calc)
  );

  always_comb
  begin
    wr_dst = 1'b0;
    wr_src = 1'b0;
    wr_dst_val = alu_res;
    if (run)
    begin
      case (cmd.op)
        rpa_pkg::OP_NOP, rpa_pkg::OP_COMPARE, rpa_pkg::OP_CLRC, rpa_pkg::OP_SETC,
        rpa_pkg::OP_RAMADR, rpa_pkg::OP_INCRAMADR, rpa_pkg::OP_DECRAMADR,
        rpa_pkg::OP_PUTEPR: wr_dst = 1'b0;
        rpa_pkg::OP_SWAP:
        begin
          wr_dst = 1'b1;
          wr_src = !cmd.src_imm;
          wr_dst_val = opb;
        end
        default: wr_dst = 1'b1;
      endcase
    end
  end

  always_comb
  begin
    ptr_next = ptr_reg;
    if (run)
    begin
      case (cmd.op)
        rpa_pkg::OP_RAMADR: ptr_next = cmd.imm[rpa_pkg::ADDR_W-1:0];
        rpa_pkg::OP_INCRAMADR: ptr_next = ptr_reg + rpa_pkg::ONE_A;
        rpa_pkg::OP_DECRAMADR: ptr_next = ptr_reg - rpa_pkg::ONE_A;
        default: ptr_next = ptr_reg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ptr_reg <= '0;
    else
      ptr_reg <= ptr_next;
  end

  // Boot copies sixteen config words before any command is taken
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= rpa_pkg::ST_BOOT;
      boot_cnt_reg <= '0;
    end
    else
    begin
      case (state_reg)
        rpa_pkg::ST_BOOT:
        begin
          boot_cnt_reg <= boot_cnt_reg + 4'h1;
          if (boot_cnt_reg == rpa_pkg::CFG_WORDS_M1)
            state_reg <= rpa_pkg::ST_RUN;
        end
        rpa_pkg::ST_RUN: state_reg <= rpa_pkg::ST_RUN;
        default: state_reg <= rpa_pkg::ST_BOOT;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      x_reg <= '0;
      y_reg <= '0;
      z_reg <= '0;
    end
    else
    begin
      // Source first so a swap's destination write wins on the same register
      if (wr_src)
      begin
        case (cmd.src)
          rpa_pkg::ACC_X: x_reg <= opa;
          rpa_pkg::ACC_Y: y_reg <= opa;
          rpa_pkg::ACC_Z: z_reg <= opa;
          default: ;
        endcase
      end
      if (wr_dst)
      begin
        case (cmd.dst)
          rpa_pkg::ACC_X: x_reg <= wr_dst_val;
          rpa_pkg::ACC_Y: y_reg <= wr_dst_val;
          rpa_pkg::ACC_Z: z_reg <= wr_dst_val;
          default: ;
        endcase
      end
    end
  end

  assign mirror_hit = front_end_mode && in_range(fe_wr.addr, rpa_pkg::ADDR_RESULT_LO,
    rpa_pkg::ADDR_RESULT_HI);
  assign mirror_addr = fe_wr.addr - rpa_pkg::RESULT_OFFSET;

  // RAM has no reset; only pointer-addressed program writes, boot and front end touch it
  always_ff @(posedge clk)
  begin
    if (state_reg == rpa_pkg::ST_BOOT)
      ram_reg[rpa_pkg::ADDR_CFG_LO + {4'h0, boot_cnt_reg}] <= cfg_word;
    else
    begin
      if (wr_dst && cmd.dst == rpa_pkg::ACC_R && user_writable(ptr_reg))
        ram_reg[ptr_reg] <= wr_dst_val;
      else if (wr_src && cmd.src == rpa_pkg::ACC_R && user_writable(ptr_reg))
        ram_reg[ptr_reg] <= opa;
      if (fe_wr.valid && in_range(fe_wr.addr, rpa_pkg::ADDR_RESULT_LO,
        rpa_pkg::ADDR_RESULT_HI))
        ram_reg[fe_wr.addr] <= fe_wr.data;
      if (fe_wr.valid && mirror_hit)
        ram_reg[mirror_addr] <= fe_wr.data;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < rpa_pkg::EPR_BYTES; i++)
        epr_reg[i] <= rpa_pkg::EPR_ERASED;
    end
    else if (run && cmd.op == rpa_pkg::OP_PUTEPR)
      epr_reg[ptr_reg[rpa_pkg::EPR_AW-1:0]] <= opa[7:0];
  end

  always_comb
  begin
    flags_next = flags_reg;
    if (run)
    begin
      case (cmd.op)
        rpa_pkg::OP_CLRC:
        begin
          flags_next.carry = 1'b0;
          flags_next.ovfl = 1'b0;
        end
        rpa_pkg::OP_SETC: flags_next.carry = 1'b1;
        default:
        begin
          if (wr_dst || cmd.op == rpa_pkg::OP_COMPARE)
          begin
            flags_next.not_zero = (wr_dst_val == rpa_pkg::ZERO_W);
            flags_next.sign = wr_dst_val[rpa_pkg::MSB];
          end
          if (alu_calc)
          begin
            flags_next.carry = alu_c;
            flags_next.ovfl = alu_v;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      flags_reg <= '0;
    else
      flags_reg <= flags_next;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cond_reg <= 1'b0;
    else
    begin
      case (cond_sel)
        rpa_pkg::CND_CARRY: cond_reg <= flags_next.carry;
        rpa_pkg::CND_NOTZERO: cond_reg <= flags_next.not_zero;
        rpa_pkg::CND_SIGN: cond_reg <= flags_next.sign;
        default: cond_reg <= flags_next.ovfl;
      endcase
    end
  end

  // Observation copies so every output leaves a flip-flop
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_r <= '0;
      cfg_index <= '0;
      boot_busy <= 1'b1;
    end
    else
    begin
      acc_r <= ram_reg[ptr_next];
      cfg_index <= boot_cnt_reg + 4'h1;
      boot_busy <= (state_reg == rpa_pkg::ST_BOOT) && (boot_cnt_reg != rpa_pkg::CFG_WORDS_M1);
    end
  end

  assign cond_true = cond_reg;
  assign flags = flags_reg;
  assign ram_ptr = ptr_reg;
  assign acc_x = x_reg;
  assign acc_y = y_reg;
  assign acc_z = z_reg;
endmodule // rpa_datapath

// ==== hw/rpa_pkg.sv ====
/*
  Package for the RAM-pointer ALU datapath: RAM map, operation codes, flag layout.
  Assumes a single processor clock and an instruction decoder that issues one op per cycle.
*/
package rpa_pkg;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned RAM_WORDS = 256;
  localparam int unsigned EPR_BYTES = 128;
  localparam int unsigned EPR_AW = 7;
  localparam int unsigned OPC_W = 5;
  localparam int unsigned SH_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_MIRROR_LO = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_MIRROR_HI = 8'h1F;
  localparam logic [ADDR_W-1:0] ADDR_CFG_LO = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_CFG_HI = 8'h3F;
  localparam logic [ADDR_W-1:0] ADDR_INT_LO = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_INT_HI = 8'h4F;
  localparam logic [ADDR_W-1:0] ADDR_UART0 = 8'h50;
  localparam logic [ADDR_W-1:0] ADDR_IREG_LO = 8'h51;
  localparam logic [ADDR_W-1:0] ADDR_IREG_HI = 8'h55;
  localparam logic [ADDR_W-1:0] ADDR_UART_LO = 8'h56;
  localparam logic [ADDR_W-1:0] ADDR_UART_HI = 8'h5B;
  localparam logic [ADDR_W-1:0] ADDR_RSV_LO = 8'h5C;
  localparam logic [ADDR_W-1:0] ADDR_RSV_HI = 8'h5F;
  localparam logic [ADDR_W-1:0] ADDR_SYS_LO = 8'hD0;
  localparam logic [ADDR_W-1:0] ADDR_SYS_HI = 8'hEF;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_LO = 8'hF0;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_HI = 8'hFF;
  localparam logic [ADDR_W-1:0] RESULT_OFFSET = 8'hE0;
  localparam logic [ADDR_W-1:0] BRIDGE1_RATIO = 8'hF0;
  localparam logic [ADDR_W-1:0] BRIDGE2_RATIO = 8'hF1;
  localparam logic [ADDR_W-1:0] BRIDGE3_RATIO = 8'hF2;
  localparam logic [ADDR_W-1:0] BRIDGE4_RATIO = 8'hF3;
  localparam logic [ADDR_W-1:0] COMPENSATED_BRIDGE_SUM = 8'hF4;
  localparam logic [ADDR_W-1:0] TEMPERATURE_RATIO = 8'hF5;
  localparam logic [ADDR_W-1:0] MEASUREMENT_STATUS_FLAGS = 8'hF6;
  localparam logic [ADDR_W-1:0] TDC_TIME_FIRST_PORT = 8'hF7;
  localparam logic [ADDR_W-1:0] TDC_RESOLUTION_CALIBRATION = 8'hF8;
  localparam logic [ADDR_W-1:0] SUPPLY_VOLTAGE_VALUE = 8'hF9;
  localparam logic [ADDR_W-1:0] KEY_FALLING_EDGES = 8'hFA;
  localparam logic [ADDR_W-1:0] KEY_RISING_EDGES = 8'hFB;
  localparam logic [ADDR_W-1:0] KEY_PRESSED_STATE = 8'hFC;
  localparam logic [ADDR_W-1:0] PIN_EDGE_AND_LEVEL_STATE = 8'hFD;
  localparam logic [ADDR_W-1:0] TIMER_AT_COMPLETION = 8'hFE;
  localparam logic [ADDR_W-1:0] SPAN_RESISTOR_RATIO = 8'hFF;
  localparam logic [ADDR_W-1:0] RESULT_COUNT_M1 = 8'h0F;
  localparam logic [DATA_W-1:0] ZERO_W = 24'h000000;
  localparam logic [DATA_W-1:0] ONE_W = 24'h000001;
  localparam logic [ADDR_W-1:0] ONE_A = 8'h01;
  localparam logic [7:0] EPR_ERASED = 8'h00;
  localparam logic [3:0] CFG_WORDS_M1 = 4'hF;
  localparam int unsigned MSB = DATA_W - 1;

  typedef enum logic [1:0] {
    ACC_X = 2'h0,
    ACC_Y = 2'h1,
    ACC_Z = 2'h2,
    ACC_R = 2'h3
  } rpa_acc_e;

  typedef enum logic [OPC_W-1:0] {
    OP_NOP = 5'h00,
    OP_MOVE = 5'h01,
    OP_SWAP = 5'h02,
    OP_CLEAR = 5'h03,
    OP_ADD = 5'h04,
    OP_SUB = 5'h05,
    OP_COMPARE = 5'h06,
    OP_INCR = 5'h07,
    OP_DECR = 5'h08,
    OP_SHIFTL = 5'h09,
    OP_SHIFTR = 5'h0A,
    OP_ROTL = 5'h0B,
    OP_ROTR = 5'h0C,
    OP_AND = 5'h0D,
    OP_OR = 5'h0E,
    OP_EOR = 5'h0F,
    OP_COMPL = 5'h10,
    OP_MULT24 = 5'h11,
    OP_CLRC = 5'h12,
    OP_SETC = 5'h13,
    OP_RAMADR = 5'h14,
    OP_INCRAMADR = 5'h15,
    OP_DECRAMADR = 5'h16,
    OP_PUTEPR = 5'h17,
    OP_GETEPR = 5'h18,
    OP_ABS = 5'h19
  } rpa_op_e;

  typedef enum logic [1:0] {
    CND_CARRY = 2'h0,
    CND_NOTZERO = 2'h1,
    CND_SIGN = 2'h2,
    CND_OVFL = 2'h3
  } rpa_cond_e;

  typedef struct packed {
    logic carry;
    logic not_zero;
    logic sign;
    logic ovfl;
  } rpa_flags_s;

  typedef struct packed {
    logic valid;
    rpa_op_e op;
    rpa_acc_e dst;
    rpa_acc_e src;
    logic src_imm;
    logic [DATA_W-1:0] imm;
  } rpa_cmd_s;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } rpa_fe_wr_s;

  typedef enum logic [1:0] {
    ST_BOOT = 2'h0,
    ST_RUN = 2'h1
  } rpa_state_e;
endpackage

// ==== test/rpa_datapath_checker.sv ====
/*
  Checker for the RAM-pointer datapath: pointer moves, flags, boot copy, RAM word.
  Assumes it is bound to rpa_datapath and sees only that module's ports.
*/
module rpa_datapath_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire rpa_pkg::rpa_cmd_s cmd,
  input wire rpa_pkg::rpa_cond_e cond_sel,
  input wire logic boot_busy,
  input wire logic cond_true,
  input wire rpa_pkg::rpa_flags_s flags,
  input wire logic [rpa_pkg::ADDR_W-1:0] ram_ptr,
  input wire logic [rpa_pkg::DATA_W-1:0] acc_x,
  input wire logic [rpa_pkg::DATA_W-1:0] acc_r
);
  timeunit 1ns;
  timeprecision 1ns;
  logic taken;
  logic ptr_op;
  logic [7:0] imm_lo;
  logic [3:0] fl;
  logic [24:0] sum_now;
  logic [24:0] sum_reg;
  logic ovf_reg;
  logic [4:0] boot_cnt;
  assign taken = cmd.valid && !boot_busy;
  assign ptr_op = taken && cmd.op inside {rpa_pkg::OP_RAMADR, rpa_pkg::OP_INCRAMADR,
    rpa_pkg::OP_DECRAMADR};
  assign imm_lo = cmd.imm[7:0];
  assign fl = flags;
  assign sum_now = {1'b0, acc_x} + {1'b0, cmd.imm};
  // Expected sum and overflow of an add-immediate, held for the next edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sum_reg <= '0;
      ovf_reg <= 1'b0;
    end
    else
    begin
      sum_reg <= sum_now;
      ovf_reg <= (acc_x[23] == cmd.imm[23]) && (sum_now[23] != acc_x[23]);
    end
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      boot_cnt <= 5'h00;
    else if (boot_busy)
      boot_cnt <= boot_cnt + 5'h01;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence add_x_s;
    taken && cmd.op == rpa_pkg::OP_ADD && cmd.dst == rpa_pkg::ACC_X && cmd.src_imm;
  endsequence
  sequence move_x_s;
    taken && cmd.op == rpa_pkg::OP_MOVE && cmd.dst == rpa_pkg::ACC_X;
  endsequence
  // Only user RAM below the protected ranges, where program writes land
  sequence move_r_s;
    taken && cmd.op == rpa_pkg::OP_MOVE && cmd.dst == rpa_pkg::ACC_R && !cmd.src_imm
      && cmd.src == rpa_pkg::ACC_X && ram_ptr < 8'h40;
  endsequence
  ptr_guard_a: assert property (
    !$past(ptr_op) |-> ram_ptr == $past(ram_ptr))
    else $error("pointer moved without a pointer command");
  ptr_load_a: assert property (
    taken && cmd.op == rpa_pkg::OP_RAMADR |=> ram_ptr == $past(imm_lo))
    else $error("pointer load wrong");
  ptr_step_a: assert property (
    taken && cmd.op == rpa_pkg::OP_INCRAMADR |=> ram_ptr == $past(ram_ptr) + 8'h01)
    else $error("pointer increment wrong");
  ptr_back_a: assert property (
    taken && cmd.op == rpa_pkg::OP_DECRAMADR |=> ram_ptr == $past(ram_ptr) - 8'h01)
    else $error("pointer decrement wrong");
  add_sum_a: assert property (
    add_x_s |=> {flags.carry, acc_x} == sum_reg)
    else $error("add result or carry wrong");
  add_ovfl_a: assert property (
    add_x_s |=> flags.ovfl == ovf_reg)
    else $error("add overflow wrong");
  move_flags_a: assert property (
    move_x_s |=> flags.sign == acc_x[23] && flags.not_zero == (acc_x == 24'h000000)
      && flags.carry == $past(flags.carry) && flags.ovfl == $past(flags.ovfl))
    else $error("move flags wrong");
  ram_word_a: assert property (
    move_r_s ##1 !cmd.valid |=> acc_r == $past(acc_x, 2))
    else $error("pointer word does not show the moved value");
  cond_pick_a: assert property (
    $stable(cond_sel) |-> cond_true == fl[3 - int'(cond_sel)])
    else $error("condition output does not match selected flag");
  boot_len_a: assert property (
    boot_busy ? boot_cnt < 5'h10 : boot_cnt == 5'h10)
    else $error("boot copy length wrong");
  boot_quiet_a: assert property (
    boot_busy |=> $stable(acc_x) && $stable(ram_ptr))
    else $error("command acted during boot");
endmodule // rpa_datapath_checker

bind rpa_datapath rpa_datapath_checker chk (.clk(clk), .resetn(resetn), .cmd(cmd),
  .cond_sel(cond_sel), .boot_busy(boot_busy), .cond_true(cond_true), .flags(flags),
  .ram_ptr(ram_ptr), .acc_x(acc_x), .acc_r(acc_r));

// ==== test/rpa_datapath_test.sv ====
/*
  Self-checking bench for the RAM-pointer datapath, one task per scenario.
  Assumes the decoder model drives commands and the boot words.
*/
module rpa_datapath_test;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(what, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("ERROR %s expected %0h seen %0h", what, exp, got); \
    end \
  end
  logic clk = 1'b0;
  logic resetn = 1'b0;
  rpa_pkg::rpa_cond_e cond_sel = rpa_pkg::CND_CARRY;
  logic front_end_mode = 1'b0;
  rpa_pkg::rpa_fe_wr_s fe_wr = '0;
  rpa_pkg::rpa_cmd_s cmd;
  logic [23:0] cfg_word;
  logic [3:0] cfg_index;
  int num_errors = 0;
  int checks_done = 0;
  always #50 clk = ~clk;
  rpa_datapath dut (.clk(clk), .resetn(resetn), .cmd(cmd), .cond_sel(cond_sel),
    .front_end_mode(front_end_mode), .fe_wr(fe_wr), .cfg_word(cfg_word),
    .cfg_index(cfg_index), .boot_busy(), .cond_true(), .flags(), .ram_ptr(),
    .acc_x(), .acc_y(), .acc_z(), .acc_r());
  rpa_decoder_model dec (.clk(clk), .cfg_index(cfg_index), .cmd(cmd), .cfg_word(cfg_word));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic ex(rpa_pkg::rpa_op_e op, rpa_pkg::rpa_acc_e d, logic [23:0] imm);
    dec.issue(op, d, d, 1'b1, imm);
  endtask
  task automatic at(logic [7:0] a);
    ex(rpa_pkg::OP_RAMADR, rpa_pkg::ACC_X, {16'h0000, a});
  endtask
  task automatic look(string what, logic [7:0] a, logic [23:0] exp);
    at(a);
    `CHK(what, exp, dut.acc_r)
  endtask
  task automatic fe(logic [7:0] a, logic [23:0] d);
    @(posedge clk);
    fe_wr <= '{1'b1, a, d};
    @(posedge clk);
    fe_wr.valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_boot;
    int n;
    ex(rpa_pkg::OP_MOVE, rpa_pkg::ACC_X, 24'h123456);
    n = 0;
    while (dut.boot_busy !== 1'b0 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    #1;
    `CHK("boot busy", 1'b0, dut.boot_busy)
    if (n == 40)
      wrap_up();
    `CHK("x after boot", 24'h000000, dut.acc_x)
    look("cfg word 0", 8'h30, 24'hC3A500);
    look("cfg word 15", 8'h3F, 24'hC3A50F);
    $display("boot test done");
  endtask
  task automatic t_ptr;
    ex(rpa_pkg::OP_MOVE, rpa_pkg::ACC_X, 24'hABCDEF);
    at(8'h03);
    dec.issue(rpa_pkg::OP_MOVE, rpa_pkg::ACC_R, rpa_pkg::ACC_X, 1'b0, 24'h000000);
    at(8'h04);
    ex(rpa_pkg::OP_MOVE, rpa_pkg::ACC_R, 24'h000111);
    look("ram 3", 8'h03, 24'hABCDEF);
    look("ram 4", 8'h04, 24'h000111);
    at(8'hFF);
    ex(rpa_pkg::OP_INCRAMADR, rpa_pkg::ACC_X, 24'h000000);
    `CHK("ptr wrap up", 8'h00, dut.ram_ptr)
    ex(rpa_pkg::OP_DECRAMADR, rpa_pkg::ACC_X, 24'h000000);
    `CHK("ptr wrap down", 8'hFF, dut.ram_ptr)
    ex(rpa_pkg::OP_MOVE, rpa_pkg::ACC_X, 24'h000001);
    `CHK("ptr kept", 8'hFF, dut.ram_ptr)
    $display("pointer test done");
  endtask
  task automatic t_epr;
    ex(rpa_pkg::OP_MOVE, rpa_pkg::ACC_X, 24'h5A5AC3);
    at(8'h04);
    ex(rpa_pkg::OP_PUTEPR, rpa_pkg::ACC_X, 24'h000000);
    `CHK("ram 4 after store", 24'h000111, dut.acc_r)
    at(8'h84);
    ex(rpa_pkg::OP_GETEPR, rpa_pkg::ACC_Y, 24'h000000);
    `CHK("fetched byte", 24'h0000C3, dut.acc_y)
    at(8'h03);
    ex(rpa_pkg::OP_GETEPR, rpa_pkg::ACC_Z, 24'h000000);
    `CHK("erased byte", 24'h000000, dut.acc_z)
    `CHK("ram 3 after fetch", 24'hABCDEF, dut.acc_r)
    dec.issue(rpa_pkg::OP_SWAP, rpa_pkg::ACC_R, rpa_pkg::ACC_X, 1'b0, 24'h000000);
    `CHK("swap x", 24'hABCDEF, dut.acc_x)
    `CHK("swap ram 3", 24'h5A5AC3, dut.acc_r)
    $display("eeprom test done");
  endtask
  task automatic t_flags;
    ex(rpa_pkg::OP_MOVE, rpa_pkg::ACC_X, 24'h7FFFFF);
    ex(rpa_pkg::OP_ADD, rpa_pkg::ACC_X, 24'h000001);
    `CHK("x sum", 24'h800000, dut.acc_x)
    `CHK("flags overflow", 4'h3, dut.flags)
    ex(rpa_pkg::OP_MOVE, rpa_pkg::ACC_Y, 24'hFFFFFF);
    ex(rpa_pkg::OP_ADD, rpa_pkg::ACC_Y, 24'h000001);
    `CHK("y sum", 24'h000000, dut.acc_y)
    `CHK("flags carry", 4'hC, dut.flags)
    ex(rpa_pkg::OP_MOVE, rpa_pkg::ACC_Z, 24'h800000);
    `CHK("flags after move", 4'hA, dut.flags)
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      cond_sel <= rpa_pkg::rpa_cond_e'(i[1:0]);
      repeat (2) @(posedge clk);
      #1;
      `CHK("cond", 4'hA >> (3 - i) & 4'h1, {3'h0, dut.cond_true})
    end
    ex(rpa_pkg::OP_CLRC, rpa_pkg::ACC_X, 24'h000000);
    ex(rpa_pkg::OP_MOVE, rpa_pkg::ACC_X, 24'h000000);
    ex(rpa_pkg::OP_SUB, rpa_pkg::ACC_X, 24'h000001);
    `CHK("x diff", 24'hFFFFFF, dut.acc_x)
    `CHK("flags borrow", 4'hA, dut.flags)
    at(8'h05);
    ex(rpa_pkg::OP_MOVE, rpa_pkg::ACC_R, 24'h000010);
    dec.issue(rpa_pkg::OP_ADD, rpa_pkg::ACC_R, rpa_pkg::ACC_X, 1'b0, 24'h000000);
    `CHK("ram word sum", 24'h00000F, dut.acc_r)
    $display("flag test done");
  endtask
  task automatic t_result;
    @(posedge clk);
    front_end_mode <= 1'b1;
    fe(8'hF4, 24'h0249F0);
    look("sum word", 8'hF4, 24'h0249F0);
    look("mirror", 8'h14, 24'h0249F0);
    at(8'hF4);
    ex(rpa_pkg::OP_MOVE, rpa_pkg::ACC_R, 24'h000000);
    look("result kept", 8'hF4, 24'h0249F0);
    at(8'h64);
    ex(rpa_pkg::OP_MOVE, rpa_pkg::ACC_R, 24'h000123);
    fe(8'h64, 24'hFFFFFF);
    look("user word", 8'h64, 24'h000123);
    @(posedge clk);
    front_end_mode <= 1'b0;
    at(8'h15);
    ex(rpa_pkg::OP_MOVE, rpa_pkg::ACC_R, 24'h00ABCD);
    fe(8'hF5, 24'h111111);
    look("stand-alone word", 8'h15, 24'h00ABCD);
    look("temperature word", 8'hF5, 24'h111111);
    $display("result map test done");
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_boot();
    t_ptr();
    t_epr();
    t_flags();
    t_result();
    wrap_up();
  end
endmodule // rpa_datapath_test

// ==== test/rpa_decoder_model.sv ====
/*
  Instruction decoder and program memory stand-in: issues one command per call.
  Assumes the datapath takes a command at the edge where valid is high.
*/
module rpa_decoder_model (
  input wire logic clk,
  input wire logic [3:0] cfg_index,
  output rpa_pkg::rpa_cmd_s cmd,
  output logic [rpa_pkg::DATA_W-1:0] cfg_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // Boot image: each word carries its own index so misplaced copies show
  assign cfg_word = 24'hC3A500 | {20'h00000, cfg_index};
  initial cmd = '0;
  task automatic issue(rpa_pkg::rpa_op_e op, rpa_pkg::rpa_acc_e d, rpa_pkg::rpa_acc_e s,
    logic si, logic [23:0] imm);
    @(posedge clk);
    cmd <= '{1'b1, op, d, s, si, imm};
    @(posedge clk);
    cmd.valid <= 1'b0;
    // Two idle edges so the pointer word has caught up before anyone looks
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule // rpa_decoder_model
